// [shared/clock_source_pkg.sv]
// constants, register map and types for the clock source control block
package clock_source_pkg;

	// ---------------------------------------------------------------
	// register offsets (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [11:0] OFF_TASK_FAST_START = 12'h000;
	localparam logic [11:0] OFF_TASK_FAST_STOP = 12'h004;
	localparam logic [11:0] OFF_TASK_SLOW_START = 12'h008;
	localparam logic [11:0] OFF_TASK_SLOW_STOP = 12'h00c;
	localparam logic [11:0] OFF_INT_ENABLE_SET = 12'h304;
	localparam logic [11:0] OFF_INT_ENABLE_CLR = 12'h308;
	localparam logic [11:0] OFF_HF_START_REQUESTED = 12'h408;
	localparam logic [11:0] OFF_HF_CLOCK_STATUS = 12'h40c;
	localparam logic [11:0] OFF_LF_START_REQUESTED = 12'h414;
	localparam logic [11:0] OFF_LF_CLOCK_STATUS = 12'h418;
	localparam logic [11:0] OFF_LF_SOURCE_SNAPSHOT = 12'h41c;
	localparam logic [11:0] OFF_LF_SOURCE_SELECT = 12'h518;
	localparam logic [11:0] OFF_HF_CRYSTAL_DEBOUNCE = 12'h528;
	localparam logic [11:0] OFF_LF_CRYSTAL_DEBOUNCE = 12'h52c;
	localparam logic [11:0] OFF_CALIBRATION_TIMER_INTERVAL = 12'h538;
	localparam logic [11:0] OFF_EVENT_STATUS = 12'h600;
	localparam logic [11:0] OFF_EVENT_CLEAR = 12'h604;
	localparam logic [11:0] OFF_INT_ENABLE = 12'h608;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int BIT_TASK = 0;
	localparam int BIT_RUN = 0;
	localparam int BIT_STATE = 16;
	localparam int BIT_HF_SRC = 0;
	localparam int LSB_SRC = 0;
	localparam int BIT_BYPASS = 16;
	localparam int BIT_EXTERNAL = 17;
	localparam int BIT_EVT_FAST = 0;
	localparam int BIT_EVT_SLOW = 1;
	localparam int W_SRC = 2;
	localparam int W_HF_DEB = 8;
	localparam int W_LF_DEB = 16;
	localparam int W_CAL_INTERVAL = 7;
	localparam int W_CNT = 16;
	localparam int N_EVT = 2;

	// ---------------------------------------------------------------
	// source encodings and reset values
	// ---------------------------------------------------------------
	localparam logic [1:0] SRC_RC = 2'h0;
	localparam logic [1:0] SRC_XTAL = 2'h1;
	localparam logic [1:0] SRC_SYNTH = 2'h2;
	localparam logic [1:0] RST_SRC = 2'h0;
	localparam logic [7:0] RST_HF_DEB = 8'h10;
	localparam logic [15:0] RST_LF_DEB = 16'h0100;
	localparam logic [6:0] RST_CAL_INTERVAL = 7'h00;

	// ---------------------------------------------------------------
	// timing: one debounce tick is one microsecond
	// ---------------------------------------------------------------
	localparam int CLK_KHZ = 25000;
	localparam int TICK_NS = 1000;
	localparam int TICK_CYCLES = (CLK_KHZ * TICK_NS + 999999) / 1000000;
	localparam int HF_POWERUP_US = 60;
	localparam logic [15:0] HF_POWERUP_TICKS = 16'(HF_POWERUP_US * 1000 / TICK_NS);

	// ---------------------------------------------------------------
	// state machines
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {HF_OFF, HF_POWERUP, HF_DEBOUNCE, HF_RUN} hf_state_t;
	typedef enum logic [1:0] {LF_OFF, LF_WAIT, LF_RUN} lf_state_t;

endpackage

// [core/clock_source_control_status.sv]
// clock source control and status unit with apb register slave
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ns
module clock_source_control_status import clock_source_pkg::*; #(
	parameter int RC_START_US = 1000 // rc start-up in ticks, shorten in simulation
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic por_rst,
	input wire logic ce,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// oscillator controls
	output logic fast_crystal_osc_en,
	output logic slow_crystal_osc_en,
	output logic slow_rc_osc_en,
	output logic slow_synthesized_clock_en,
	output logic slow_bypass,
	output logic slow_external,
	// events and interrupt
	output logic fast_clock_started_event,
	output logic slow_clock_started_event,
	output logic irq
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	// every register of the block lives in one packed struct so that a
	// single always_ff carries both resets and the clock enable; the
	// retained interval is the only field the ordinary reset must skip
	typedef struct packed {
		logic hf_run; // fast start task seen
		hf_state_t hf_state; // fast crystal sequence
		logic [W_CNT-1:0] hf_cnt; // fast remaining ticks
		logic lf_run; // slow start task seen
		lf_state_t lf_state; // slow clock sequence
		logic [W_CNT-1:0] lf_cnt; // slow remaining ticks
		logic [4:0] presc; // tick prescaler
		logic [W_SRC-1:0] lf_src; // selected slow source
		logic lf_bypass; // crystal bypass
		logic lf_ext; // external source instead of crystal
		logic [W_SRC-1:0] lf_copy; // source captured at start
		logic [W_HF_DEB-1:0] hf_deb; // fast debounce ticks
		logic [W_LF_DEB-1:0] lf_deb; // slow debounce ticks
		logic [W_CAL_INTERVAL-1:0] cal_interval; // retained calibration interval
		logic [N_EVT-1:0] evt; // sticky event status
		logic [N_EVT-1:0] inten; // interrupt enables
		logic hf_pulse; // fast started pulse
		logic lf_pulse; // slow started pulse
		logic [31:0] rdata; // read data for access phase
		logic err; // unmapped address answer
	} state_t;

	// current and next state
	state_t s_q;
	state_t s_d;
	// helpers, all combinational
	logic tick; // one microsecond strobe
	logic wr; // write in access phase
	logic setup; // setup phase
	logic [31:0] rd; // read mux
	logic mapped; // address decodes
	logic hf_done; // fast sequence finishing
	logic lf_done; // slow sequence finishing
	logic [N_EVT-1:0] evt_set; // hardware events this cycle

	// prescaler wraps once per microsecond tick; five bits cover the 25
	// cycles of a 40 ns clock, a clock above 32 MHz would need a wider field
	localparam logic [4:0] PRESC_LAST = 5'(TICK_CYCLES - 1);
	// rc start-up is a fixed wait, counted in the same ticks as debounce
	localparam logic [W_CNT-1:0] RC_TICKS = W_CNT'(RC_START_US);

	// ---------------------------------------------------------------
	// apb decode
	// ---------------------------------------------------------------
	// one-cycle strobe on the last prescaler count
	assign tick = (s_q.presc == PRESC_LAST);
	// setup cycle: the only cycle that loads read data and error
	assign setup = psel && !penable;
	// access cycle of a write; pready is always high, so this is the
	// edge at which the write lands, with no wait states to count
	assign wr = psel && penable && pwrite;

	// read mux and address check
	// unused bits read as zero; an address outside the map is flagged
	// here and answered with an error in the access cycle, so software
	// sees a refused access rather than silent zero data
	always_comb begin
		rd = 32'h0000_0000;
		mapped = 1'b1;
		unique case (paddr)
			OFF_TASK_FAST_START, OFF_TASK_FAST_STOP,
			OFF_TASK_SLOW_START, OFF_TASK_SLOW_STOP,
			OFF_EVENT_CLEAR: begin
				rd = 32'h0000_0000; // write-only, read zero
			end
			// all three enable addresses read back the same enable bits
			OFF_INT_ENABLE_SET, OFF_INT_ENABLE_CLR, OFF_INT_ENABLE: begin
				rd[N_EVT-1:0] = s_q.inten;
			end
			// run flag: start task seen, cleared by stop or reset
			OFF_HF_START_REQUESTED: begin
				rd[BIT_RUN] = s_q.hf_run;
			end
			// bit 0 crystal powered, bit 16 started event already given
			OFF_HF_CLOCK_STATUS: begin
				rd[BIT_HF_SRC] = (s_q.hf_state != HF_OFF);
				rd[BIT_STATE] = (s_q.hf_state == HF_RUN);
			end
			// slow run flag, same life as the fast one
			OFF_LF_START_REQUESTED: begin
				rd[BIT_RUN] = s_q.lf_run;
			end
			// source shown is the one captured at start, not the live
			// select, so a later select write does not alter the status
			OFF_LF_CLOCK_STATUS: begin
				rd[LSB_SRC +: W_SRC] = s_q.lf_copy;
				rd[BIT_STATE] = (s_q.lf_state == LF_RUN);
			end
			// copy taken by the slow start task; writes are ignored
			OFF_LF_SOURCE_SNAPSHOT: begin
				rd[LSB_SRC +: W_SRC] = s_q.lf_copy;
			end
			// live select with its bypass and external bits
			OFF_LF_SOURCE_SELECT: begin
				rd[LSB_SRC +: W_SRC] = s_q.lf_src;
				rd[BIT_BYPASS] = s_q.lf_bypass;
				rd[BIT_EXTERNAL] = s_q.lf_ext;
			end
			// debounce and interval registers read back as written
			OFF_HF_CRYSTAL_DEBOUNCE: begin
				rd[W_HF_DEB-1:0] = s_q.hf_deb;
			end
			OFF_LF_CRYSTAL_DEBOUNCE: begin
				rd[W_LF_DEB-1:0] = s_q.lf_deb;
			end
			OFF_CALIBRATION_TIMER_INTERVAL: begin
				rd[W_CAL_INTERVAL-1:0] = s_q.cal_interval;
			end
			// sticky events, cleared only through the clear register or a reset
			OFF_EVENT_STATUS: begin
				rd[N_EVT-1:0] = s_q.evt;
			end
			default: begin
				mapped = 1'b0; // unmapped: error, zero data
			end
		endcase
	end

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	// every field holds unless a branch below moves it; the started
	// pulses default low so that each lasts exactly one cycle
	always_comb begin
		s_d = s_q;
		hf_done = 1'b0;
		lf_done = 1'b0;
		s_d.hf_pulse = 1'b0;
		s_d.lf_pulse = 1'b0;

		// free-running microsecond prescaler
		s_d.presc = tick ? 5'h00 : s_q.presc + 5'h01;

		// latch read data and error in setup so they stand in access
		// prdata then holds until the next setup, whatever comes between
		if (setup) begin
			s_d.rdata = pwrite ? 32'h0000_0000 : rd;
			s_d.err = !mapped;
		end

		// fast crystal sequence: power-up, then debounce
		unique case (s_q.hf_state)
			HF_OFF: begin
				// idle until the fast start task
			end
			HF_POWERUP: begin
				// fixed power-up time, counted down in microsecond ticks
				if (tick) begin
					if (s_q.hf_cnt <= 16'h0001) begin
						s_d.hf_state = HF_DEBOUNCE;
						s_d.hf_cnt = W_CNT'(s_q.hf_deb);
					end else begin
						s_d.hf_cnt = s_q.hf_cnt - 16'h0001;
					end
				end
			end
			HF_DEBOUNCE: begin
				// programmed debounce; a zero setting finishes at once
				if (s_q.hf_cnt == 16'h0000) begin
					hf_done = 1'b1;
				end else if (tick) begin
					s_d.hf_cnt = s_q.hf_cnt - 16'h0001;
				end
			end
			HF_RUN: begin
				// running until the stop task
			end
		endcase
		if (hf_done) begin
			s_d.hf_state = HF_RUN;
			s_d.hf_pulse = 1'b1;
		end

		// slow clock sequence, wait depends on the captured source
		unique case (s_q.lf_state)
			LF_OFF: begin
				// idle until the slow start task
			end
			LF_WAIT: begin
				// rc and crystal count down; synthesized waits on the fast clock
				if (s_q.lf_copy == SRC_SYNTH) begin
					// synthesized clock needs the fast clock first
					// and waits for as long as the fast clock stays off
					lf_done = (s_q.hf_state == HF_RUN);
				end else if (s_q.lf_cnt == 16'h0000) begin
					lf_done = 1'b1;
				end else if (tick) begin
					s_d.lf_cnt = s_q.lf_cnt - 16'h0001;
				end
			end
			LF_RUN: begin
				// running until the stop task
			end
		endcase
		if (lf_done) begin
			s_d.lf_state = LF_RUN;
			s_d.lf_pulse = 1'b1;
		end

		// register writes, taken in access phase
		// with ce low the whole state is frozen, so such writes are lost
		if (wr) begin
			unique case (paddr)
				// a repeated start only sets the run flag again
				OFF_TASK_FAST_START: begin
					if (pwdata[BIT_TASK]) begin
						s_d.hf_run = 1'b1;
						if (s_q.hf_state == HF_OFF) begin
							s_d.hf_state = HF_POWERUP;
							s_d.hf_cnt = HF_POWERUP_TICKS;
						end
					end
				end
				// stop powers the crystal down and drops the run flag
				OFF_TASK_FAST_STOP: begin
					if (pwdata[BIT_TASK]) begin
						s_d.hf_run = 1'b0;
						s_d.hf_state = HF_OFF;
						s_d.hf_pulse = 1'b0;
					end
				end
				// the copy is retaken on every start, running or not
				OFF_TASK_SLOW_START: begin
					if (pwdata[BIT_TASK]) begin
						s_d.lf_run = 1'b1;
						s_d.lf_copy = s_q.lf_src;
						if (s_q.lf_state == LF_OFF) begin
							s_d.lf_state = LF_WAIT;
							// crystal waits its debounce, rc its start time
							s_d.lf_cnt = (s_q.lf_src == SRC_XTAL) ? s_q.lf_deb : RC_TICKS;
						end
					end
				end
				// stop ends the slow clock; the captured source is kept
				OFF_TASK_SLOW_STOP: begin
					if (pwdata[BIT_TASK]) begin
						s_d.lf_run = 1'b0;
						s_d.lf_state = LF_OFF;
						s_d.lf_pulse = 1'b0;
					end
				end
				// write one sets, zeros leave enables alone
				OFF_INT_ENABLE_SET: begin
					s_d.inten = s_q.inten | pwdata[N_EVT-1:0];
				end
				// write one clears, zeros leave enables alone
				OFF_INT_ENABLE_CLR: begin
					s_d.inten = s_q.inten & ~pwdata[N_EVT-1:0];
				end
				// plain write of the whole enable set
				OFF_INT_ENABLE: begin
					s_d.inten = pwdata[N_EVT-1:0];
				end
				// the source takes effect at the next slow start only; bypass and external at once
				OFF_LF_SOURCE_SELECT: begin
					s_d.lf_src = pwdata[LSB_SRC +: W_SRC];
					s_d.lf_bypass = pwdata[BIT_BYPASS];
					s_d.lf_ext = pwdata[BIT_EXTERNAL];
				end
				OFF_HF_CRYSTAL_DEBOUNCE: begin
					// no interlock: changing it mid start-up is software's fault
					s_d.hf_deb = pwdata[W_HF_DEB-1:0];
				end
				// no such hazard: the value is copied into the counter at the slow start task
				OFF_LF_CRYSTAL_DEBOUNCE: begin
					s_d.lf_deb = pwdata[W_LF_DEB-1:0];
				end
				// kept through the ordinary reset, see the state register
				OFF_CALIBRATION_TIMER_INTERVAL: begin
					s_d.cal_interval = pwdata[W_CAL_INTERVAL-1:0];
				end
				// write one clears; a set in the same cycle wins below
				OFF_EVENT_CLEAR: begin
					s_d.evt = s_q.evt & ~pwdata[N_EVT-1:0];
				end
				default: begin
				end
			endcase
		end

		// sticky events: a set in the clearing cycle still lands
		evt_set = '0;
		evt_set[BIT_EVT_FAST] = s_d.hf_pulse;
		evt_set[BIT_EVT_SLOW] = s_d.lf_pulse;
		s_d.evt = s_d.evt | evt_set;
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	// both resets are synchronous and act whatever ce is; ce low
	// freezes every field, prescaler included
	always_ff @(posedge clk) begin
		if (por_rst) begin
			// power-on resets everything, the retained interval too
			s_q <= '0;
			s_q.hf_deb <= RST_HF_DEB;
			s_q.lf_deb <= RST_LF_DEB;
			s_q.cal_interval <= RST_CAL_INTERVAL;
		end else if (sys_rst) begin
			// ordinary reset keeps the calibration interval
			s_q <= '0;
			s_q.lf_src <= RST_SRC;
			s_q.lf_copy <= RST_SRC;
			s_q.hf_deb <= RST_HF_DEB;
			s_q.lf_deb <= RST_LF_DEB;
			s_q.cal_interval <= s_q.cal_interval;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	// zero wait states: every access completes at its first edge
	assign pready = 1'b1;
	assign prdata = s_q.rdata;
	assign pslverr = psel && penable && s_q.err;
	assign fast_crystal_osc_en = (s_q.hf_state != HF_OFF);
	// crystal only powered when the captured source is crystal
	assign slow_crystal_osc_en = (s_q.lf_state != LF_OFF) && (s_q.lf_copy == SRC_XTAL);
	assign slow_rc_osc_en = (s_q.lf_state != LF_OFF) && (s_q.lf_copy == SRC_RC);
	assign slow_synthesized_clock_en = (s_q.lf_state == LF_RUN) && (s_q.lf_copy == SRC_SYNTH);
	// bypass and external follow the select at once
	assign slow_bypass = s_q.lf_bypass;
	assign slow_external = s_q.lf_ext;
	// started events are registered one-cycle pulses
	assign fast_clock_started_event = s_q.hf_pulse;
	assign slow_clock_started_event = s_q.lf_pulse;
	// level interrupt, high while any enabled event is pending
	assign irq = |(s_q.evt & s_q.inten);

endmodule

// [tb/clock_source_control_status_assertions.sv]
// port assertions for the clock source control block
`timescale 1ns/1ns
module clock_source_control_status_assertions import clock_source_pkg::*; (
	// clock and resets
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic por_rst,
	input wire logic ce,
	// apb side
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pslverr,
	// oscillators and events
	input wire logic fast_crystal_osc_en,
	input wire logic slow_crystal_osc_en,
	input wire logic slow_rc_osc_en,
	input wire logic slow_bypass,
	input wire logic slow_external,
	input wire logic fast_clock_started_event,
	input wire logic slow_clock_started_event
);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	logic wr_s; // a write lands at this edge
	assign wr_s = psel && penable && pwrite && ce;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst || por_rst);
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	property p_byp;
		wr_s && paddr == OFF_LF_SOURCE_SELECT |=> slow_bypass == $past(pwdata[BIT_BYPASS]);
	endproperty
	a_byp: assert property (p_byp)
		else $error("bypass pin missed its write");
	property p_ext;
		wr_s && paddr == OFF_LF_SOURCE_SELECT |=> slow_external == $past(pwdata[BIT_EXTERNAL]);
	endproperty
	a_ext: assert property (p_ext)
		else $error("external pin missed its write");
	property p_fon; wr_s && paddr == OFF_TASK_FAST_START && pwdata[0] |=> fast_crystal_osc_en; endproperty
	a_fon: assert property (p_fon)
		else $error("fast crystal not started");
	// power-up alone spans far more than eight cycles
	property p_fearly; $rose(fast_crystal_osc_en) |-> !fast_clock_started_event [*8]; endproperty
	a_fearly: assert property (p_fearly)
		else $error("fast started too early");
	property p_fev; fast_clock_started_event |-> fast_crystal_osc_en; endproperty
	a_fev: assert property (p_fev)
		else $error("fast started with crystal off");
	property p_fpulse; fast_clock_started_event |=> !fast_clock_started_event; endproperty
	a_fpulse: assert property (p_fpulse)
		else $error("fast started pulse too long");
	property p_spulse; slow_clock_started_event |=> !slow_clock_started_event; endproperty
	a_spulse: assert property (p_spulse)
		else $error("slow started pulse too long");
	property p_sdeb; $rose(slow_crystal_osc_en) |-> !slow_clock_started_event [*8]; endproperty
	a_sdeb: assert property (p_sdeb)
		else $error("slow started before debounce");
	property p_one; slow_crystal_osc_en |-> !slow_rc_osc_en; endproperty
	a_one: assert property (p_one)
		else $error("two slow sources enabled");
	property p_err; psel && penable && paddr == 12'h7fc |-> pslverr; endproperty
	a_err: assert property (p_err)
		else $error("unmapped access not refused");
endmodule
bind clock_source_control_status clock_source_control_status_assertions i_chk (
	.clk(clk), .sys_rst(sys_rst), .por_rst(por_rst), .ce(ce), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
	.fast_crystal_osc_en(fast_crystal_osc_en), .slow_crystal_osc_en(slow_crystal_osc_en),
	.slow_rc_osc_en(slow_rc_osc_en), .slow_bypass(slow_bypass), .slow_external(slow_external),
	.fast_clock_started_event(fast_clock_started_event),
	.slow_clock_started_event(slow_clock_started_event)
);

// [tb/clock_source_control_status_tb_top.sv]
// self-checking bench for the clock source control block
`timescale 1ns/1ns
module clock_source_control_status_tb_top import clock_source_pkg::*; ();
	// ------------------------------------------------------------
	// stimulus and observed signals
	// ------------------------------------------------------------
	logic clk = 0, sys_rst = 1, por_rst = 1, ce = 1;
	logic psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, q;
	logic pready, pslverr, e, fx, sx, rc, sy, byp, ext, fev, sev, irq;
	int fail_count = 0, num_checks = 0, cyc = 0, n;
	initial forever #20 clk = ~clk;
	// rc start shortened to five ticks
	clock_source_control_status #(.RC_START_US(5)) i_dut (.clk(clk), .sys_rst(sys_rst),
		.por_rst(por_rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.fast_crystal_osc_en(fx), .slow_crystal_osc_en(sx), .slow_rc_osc_en(rc),
		.slow_synthesized_clock_en(sy), .slow_bypass(byp), .slow_external(ext),
		.fast_clock_started_event(fev), .slow_clock_started_event(sev), .irq(irq));
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		num_checks++;
		if (g !== x) begin
			$display("unexpected %s: expected %h seen %h", nm, x, g);
			fail_count++;
		end
	endtask
	// one apb transfer; waits on pready, idles one cycle after
	// only the global cycle ceiling ends a stalled wait
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] x);
		bus(1'b0, a, 32'h0);
		chk(nm, x, q);
	endtask
	// counts cycles up to a started pulse, bounded
	task automatic wait_ev(input logic f);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while ((f ? fev : sev) !== 1'b1 && n < 5000);
	endtask
	// delay window: one tick of phase slack plus bus overhead
	task automatic win(input string nm, input int x);
		chk(nm, 32'h1, {31'h0, n >= x - TICK_CYCLES - 10 && n <= x + TICK_CYCLES});
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		rdc("source select", OFF_LF_SOURCE_SELECT, 32'h0);
		rdc("snapshot", OFF_LF_SOURCE_SNAPSHOT, 32'h0);
		rdc("fast run", OFF_HF_START_REQUESTED, 32'h0);
		rdc("slow run", OFF_LF_START_REQUESTED, 32'h0);
		rdc("slow status", OFF_LF_CLOCK_STATUS, 32'h0);
		bus(1'b0, 12'h7fc, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, e});
	endtask
	task automatic t_src();
		logic [31:0] tab [3];
		tab = '{32'h0, 32'h30001, 32'h10002};
		foreach (tab[i]) begin
			bus(1'b1, OFF_LF_SOURCE_SELECT, tab[i]);
			rdc("source select", OFF_LF_SOURCE_SELECT, tab[i]);
			chk("bypass pin", {31'h0, tab[i][16]}, {31'h0, byp});
			chk("external pin", {31'h0, tab[i][17]}, {31'h0, ext});
		end
		// read-only copy ignores writes
		bus(1'b1, OFF_LF_SOURCE_SNAPSHOT, 32'h2);
		rdc("snapshot", OFF_LF_SOURCE_SNAPSHOT, 32'h0);
	endtask
	task automatic t_fast();
		bus(1'b1, OFF_HF_CRYSTAL_DEBOUNCE, 32'h1);
		bus(1'b1, OFF_INT_ENABLE_SET, 32'h1);
		bus(1'b1, OFF_TASK_FAST_START, 32'h1);
		chk("fast osc", 32'h1, {31'h0, fx});
		rdc("fast run", OFF_HF_START_REQUESTED, 32'h1);
		wait_ev(1'b1);
		win("fast delay", (HF_POWERUP_US + 1) * TICK_CYCLES);
		rdc("fast status", OFF_HF_CLOCK_STATUS, 32'h10001);
		chk("irq raised", 32'h1, {31'h0, irq});
		bus(1'b1, OFF_INT_ENABLE_CLR, 32'h1);
		rdc("enables", OFF_INT_ENABLE_SET, 32'h0);
		chk("irq masked", 32'h0, {31'h0, irq});
		rdc("events", OFF_EVENT_STATUS, 32'h1);
		bus(1'b1, OFF_EVENT_CLEAR, 32'h1);
		rdc("events cleared", OFF_EVENT_STATUS, 32'h0);
		// synthesized slow clock runs as soon as the fast clock does
		bus(1'b1, OFF_LF_SOURCE_SELECT, 32'(SRC_SYNTH));
		bus(1'b1, OFF_TASK_SLOW_START, 32'h1);
		rdc("synth status", OFF_LF_CLOCK_STATUS, 32'h10002);
		chk("synth clock", 32'h1, {31'h0, sy});
		rdc("synth event", OFF_EVENT_STATUS, 32'h2);
		bus(1'b1, OFF_TASK_SLOW_STOP, 32'h1);
		bus(1'b1, OFF_EVENT_CLEAR, 32'h2);
		chk("synth clock off", 32'h0, {31'h0, sy});
		bus(1'b1, OFF_TASK_FAST_STOP, 32'h1);
		chk("fast osc off", 32'h0, {31'h0, fx});
	endtask
	task automatic t_slow();
		bus(1'b1, OFF_LF_CRYSTAL_DEBOUNCE, 32'h2);
		bus(1'b1, OFF_LF_SOURCE_SELECT, 32'(SRC_XTAL));
		bus(1'b1, OFF_TASK_SLOW_START, 32'h1);
		chk("slow xtal", 32'h1, {31'h0, sx});
		chk("slow rc", 32'h0, {31'h0, rc});
		rdc("slow run", OFF_LF_START_REQUESTED, 32'h1);
		rdc("snapshot", OFF_LF_SOURCE_SNAPSHOT, 32'h1);
		wait_ev(1'b0);
		win("slow delay", 2 * TICK_CYCLES);
		rdc("slow status", OFF_LF_CLOCK_STATUS, 32'h10001);
		rdc("events", OFF_EVENT_STATUS, 32'h2);
		chk("irq stays low", 32'h0, {31'h0, irq});
		bus(1'b1, OFF_TASK_SLOW_STOP, 32'h1);
		rdc("slow stopped", OFF_LF_CLOCK_STATUS, 32'h1);
		bus(1'b1, OFF_LF_SOURCE_SELECT, 32'(SRC_RC));
		bus(1'b1, OFF_TASK_SLOW_START, 32'h1);
		chk("rc on", 32'h1, {31'h0, rc});
		chk("xtal off", 32'h0, {31'h0, sx});
		wait_ev(1'b0);
		win("rc delay", 5 * TICK_CYCLES);
		rdc("rc status", OFF_LF_CLOCK_STATUS, 32'h10000);
	endtask
	task automatic t_retain();
		bus(1'b1, OFF_CALIBRATION_TIMER_INTERVAL, 32'h55);
		// clock enable low freezes state: this write must be lost
		ce <= 1'b0;
		bus(1'b1, OFF_CALIBRATION_TIMER_INTERVAL, 32'h11);
		ce <= 1'b1;
		rdc("frozen write", OFF_CALIBRATION_TIMER_INTERVAL, 32'h55);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		rdc("interval kept", OFF_CALIBRATION_TIMER_INTERVAL, 32'h55);
		rdc("slow run cleared", OFF_LF_START_REQUESTED, 32'h0);
		por_rst <= 1'b1;
		repeat (2) @(posedge clk);
		por_rst <= 1'b0;
		rdc("interval cleared", OFF_CALIBRATION_TIMER_INTERVAL, 32'h0);
	endtask
	// ------------------------------------------------------------
	// closing report and hang guard
	// ------------------------------------------------------------
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			finish_test();
		end
	end
	initial begin
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		por_rst <= 1'b0;
		t_reset();
		t_src();
		t_fast();
		t_slow();
		t_retain();
		finish_test();
	end
endmodule
